// ---- common/rprc_defines.vh ----
// register map constants for the per-port remap configuration bank
// assumes an 8-bit local register address and 8-bit data
`ifndef RPRC_DEFINES_VH
`define RPRC_DEFINES_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define RPRC_OFF_PORT_SEL    8'h4C
`define RPRC_OFF_FWD_CTL     8'h59
`define RPRC_OFF_FWD_SPARE   8'h5A
`define RPRC_OFF_SER_ADDR    8'h5B
`define RPRC_OFF_SER_ALIAS   8'h5C
`define RPRC_OFF_TGT0        8'h5D
`define RPRC_OFF_TGT1        8'h5E
`define RPRC_OFF_TGT2        8'h5F

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define RPRC_FWD_OVR_BIT     7
`define RPRC_FWD_GPIO_HI     1
`define RPRC_FWD_GPIO_LO     0
`define RPRC_ADDR_HI         7
`define RPRC_ADDR_LO         1
`define RPRC_HOLD_BIT        0
`define RPRC_AACK_BIT        0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RPRC_RST_BYTE        8'h00
`define RPRC_RST_ADDR        7'h00
`define RPRC_RST_GPIO        2'h0
`define RPRC_RST_PORT_SEL    2'h0

`endif

// ---- hdl/rprc_bank.v ----
// per-receive-port remap configuration bank with alias decode and remap
// assumes a local register access port and forward-channel load ports
`timescale 1ns/1ps
`include "rprc_defines.vh"

module rprc_bank #(
    parameter NPORT = 4,
    parameter NTGT  = 3
) (
    input  wire        clk_sys,
    input  wire        nrst,
    input  wire        reg_wr,
    input  wire        reg_rd,
    input  wire [7:0]  reg_addr,
    input  wire [7:0]  reg_wdata,
    output reg  [7:0]  reg_rdata,
    input  wire        fwd_ctl_load,
    input  wire [1:0]  fwd_ctl_port,
    input  wire [1:0]  fwd_gpio_count_in,
    input  wire        fwd_id_load,
    input  wire [1:0]  fwd_id_port,
    input  wire [6:0]  fwd_ser_addr_in,
    input  wire        txn_req,
    input  wire [6:0]  txn_addr,
    input  wire        txn_write,
    input  wire [NTGT*7-1:0] tgt_alias_flat,
    output reg         fwd_req,
    output reg  [1:0]  fwd_port,
    output reg  [6:0]  fwd_addr,
    output reg         local_ack,
    output reg  [2:0]  port0_gpio_enabled,
    output reg  [1:0]  port_sel
);

    // ----------------------------------------------------------------
    // storage
    // ----------------------------------------------------------------
    reg         ovr_r     [0:NPORT-1];
    reg  [1:0]  gpio_r    [0:NPORT-1];
    reg  [6:0]  saddr_r   [0:NPORT-1];
    reg         hold_r    [0:NPORT-1];
    reg  [6:0]  alias_r   [0:NPORT-1];
    reg         aack_r    [0:NPORT-1];
    reg  [6:0]  tgt_r     [0:NPORT*NTGT-1];
    reg  [1:0]  port_sel_r;
    reg  [7:0]  rdata_nxt;
    integer     i;
    integer     t;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function [2:0] gpio_decode;
        input [1:0] code;
        begin
            case (code)
                2'h0: gpio_decode = 3'h0;
                2'h1: gpio_decode = 3'h1;
                2'h2: gpio_decode = 3'h2;
                2'h3: gpio_decode = 3'h4;
                default: gpio_decode = 3'h0;
            endcase
        end
    endfunction

    function is_tgt;
        input [7:0] a;
        begin
            is_tgt = (a >= `RPRC_OFF_TGT0) && (a < `RPRC_OFF_TGT0 + NTGT);
        end
    endfunction

    wire [7:0] tgt_idx = reg_addr - `RPRC_OFF_TGT0;

    // ----------------------------------------------------------------
    // register writes and forward-channel loads
    // ----------------------------------------------------------------
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            port_sel_r <= `RPRC_RST_PORT_SEL;
            for (i = 0; i < NPORT; i = i + 1) begin
                ovr_r[i]   <= 1'b0;
                gpio_r[i]  <= `RPRC_RST_GPIO;
                saddr_r[i] <= `RPRC_RST_ADDR;
                hold_r[i]  <= 1'b0;
                alias_r[i] <= `RPRC_RST_ADDR;
                aack_r[i]  <= 1'b0;
            end
            for (i = 0; i < NPORT*NTGT; i = i + 1) begin
                tgt_r[i] <= `RPRC_RST_ADDR;
            end
        end else begin
            // forward loads first so a local write in the same cycle wins
            if (fwd_ctl_load && !ovr_r[fwd_ctl_port]) begin
                gpio_r[fwd_ctl_port] <= fwd_gpio_count_in;
            end
            if (fwd_id_load && !hold_r[fwd_id_port]) begin
                saddr_r[fwd_id_port] <= fwd_ser_addr_in;
            end
            if (reg_wr) begin
                if (reg_addr == `RPRC_OFF_PORT_SEL) begin
                    port_sel_r <= reg_wdata[1:0];
                end
                if (reg_addr == `RPRC_OFF_FWD_CTL) begin
                    ovr_r[port_sel_r] <= reg_wdata[`RPRC_FWD_OVR_BIT];
                    if (reg_wdata[`RPRC_FWD_OVR_BIT] || ovr_r[port_sel_r]) begin
                        gpio_r[port_sel_r] <= reg_wdata[`RPRC_FWD_GPIO_HI:`RPRC_FWD_GPIO_LO];
                    end
                end
                if (reg_addr == `RPRC_OFF_SER_ADDR) begin
                    saddr_r[port_sel_r] <= reg_wdata[`RPRC_ADDR_HI:`RPRC_ADDR_LO];
                    hold_r[port_sel_r]  <= reg_wdata[`RPRC_HOLD_BIT];
                end
                if (reg_addr == `RPRC_OFF_SER_ALIAS) begin
                    alias_r[port_sel_r] <= reg_wdata[`RPRC_ADDR_HI:`RPRC_ADDR_LO];
                    aack_r[port_sel_r]  <= reg_wdata[`RPRC_AACK_BIT];
                end
                if (is_tgt(reg_addr)) begin
                    tgt_r[port_sel_r*NTGT + tgt_idx] <= reg_wdata[`RPRC_ADDR_HI:`RPRC_ADDR_LO];
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // read mux
    // ----------------------------------------------------------------
    always @* begin
        rdata_nxt = `RPRC_RST_BYTE;
        case (reg_addr)
            `RPRC_OFF_PORT_SEL:  rdata_nxt = {6'h00, port_sel_r};
            `RPRC_OFF_FWD_CTL:   rdata_nxt = {ovr_r[port_sel_r], 5'h00, gpio_r[port_sel_r]};
            `RPRC_OFF_FWD_SPARE: rdata_nxt = `RPRC_RST_BYTE;
            `RPRC_OFF_SER_ADDR:  rdata_nxt = {saddr_r[port_sel_r], hold_r[port_sel_r]};
            `RPRC_OFF_SER_ALIAS: rdata_nxt = {alias_r[port_sel_r], aack_r[port_sel_r]};
            default: begin
                if (is_tgt(reg_addr)) begin
                    rdata_nxt = {tgt_r[port_sel_r*NTGT + tgt_idx], 1'b0};
                end
            end
        endcase
    end

    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= `RPRC_RST_BYTE;
        end else if (reg_rd) begin
            reg_rdata <= rdata_nxt;
        end
    end

    // ----------------------------------------------------------------
    // alias decode and remap of local transactions on selected port
    // ----------------------------------------------------------------
    reg        hit_nxt;
    reg        ack_nxt;
    reg  [6:0] addr_nxt;
    always @* begin
        hit_nxt  = 1'b0;
        ack_nxt  = 1'b0;
        addr_nxt = 7'h00;
        if (alias_r[port_sel_r] != 7'h00 && txn_addr == alias_r[port_sel_r]) begin
            hit_nxt  = 1'b1;
            addr_nxt = saddr_r[port_sel_r];
            ack_nxt  = txn_write && aack_r[port_sel_r];
        end
        for (t = 0; t < NTGT; t = t + 1) begin
            if (!hit_nxt && tgt_alias_flat[t*7 +: 7] != 7'h00 && txn_addr == tgt_alias_flat[t*7 +: 7]) begin
                hit_nxt  = 1'b1;
                addr_nxt = tgt_r[port_sel_r*NTGT + t];
            end
        end
    end

    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            fwd_req            <= 1'b0;
            fwd_port           <= 2'h0;
            fwd_addr           <= 7'h00;
            local_ack          <= 1'b0;
            port0_gpio_enabled <= 3'h0;
            port_sel           <= `RPRC_RST_PORT_SEL;
        end else begin
            fwd_req            <= txn_req && hit_nxt;
            fwd_port           <= port_sel_r;
            fwd_addr           <= addr_nxt;
            local_ack          <= txn_req && ack_nxt;
            port0_gpio_enabled <= gpio_decode(gpio_r[0]);
            port_sel           <= port_sel_r;
        end
    end

endmodule // rprc_bank

// ---- sim/rprc_bank_assertions.sv ----
// checker for the remap bank top ports
// assumes one clock domain, bound onto rprc_bank
`timescale 1ns/1ps
module rprc_bank_chk (
    input logic       clk_sys,
    input logic       nrst,
    input logic       reg_wr,
    input logic       reg_rd,
    input logic [7:0] reg_addr,
    input logic [7:0] reg_rdata,
    input logic       fwd_ctl_load,
    input logic [1:0] fwd_ctl_port,
    input logic       txn_req,
    input logic [6:0] txn_addr,
    input logic       txn_write,
    input logic       fwd_req,
    input logic [1:0] fwd_port,
    input logic       local_ack,
    input logic [2:0] port0_gpio_enabled,
    input logic [1:0] port_sel
);
    // ----
    // properties
    // ----
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    sequence txn_s; txn_req ##1 fwd_req; endsequence
    sequence ack_s; txn_req && txn_write ##1 local_ack; endsequence
    req_after_txn_a: assert property (fwd_req |-> $past(txn_req)) else $error("fwd_req without txn");
    zero_nomatch_a: assert property (txn_req && txn_addr == 7'h00 |=> !fwd_req)
        else $error("zero address forwarded");
    ack_needs_wr_a: assert property (local_ack |-> $past(txn_req && txn_write)) else $error("ack not write");
    ack_with_fwd_a: assert property (ack_s |-> fwd_req) else $error("ack without forward");
    fwd_port_a: assert property (txn_s |-> fwd_port == port_sel) else $error("wrong fwd_port");
    gpio_decode_a: assert property (port0_gpio_enabled inside {3'h0, 3'h1, 3'h2, 3'h4})
        else $error("bad gpio decode");
    gpio_cause_a: assert property (!$stable(port0_gpio_enabled) |-> $past(fwd_ctl_load && fwd_ctl_port == 2'h0, 2)
        || $past(reg_wr && reg_addr == 8'h59, 2) && $past(port_sel) == 2'h0) else $error("gpio changed uncaused");
    psel_cause_a: assert property (!$stable(port_sel) |-> $past(reg_wr && reg_addr == 8'h4C, 2))
        else $error("port_sel changed uncaused");
    rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata)) else $error("rdata moved");
endmodule // rprc_bank_chk
bind rprc_bank rprc_bank_chk u_chk (.*);

// ---- sim/rprc_ser_model.sv ----
// remote serializer model on the forward-channel load ports
// assumes tb calls its tasks; drives at falling edges
`timescale 1ns/1ps
module rprc_ser_model (
    input  logic       clk_sys,
    output logic       fwd_ctl_load = 1'b0,
    output logic [1:0] fwd_ctl_port = 2'h0,
    output logic [1:0] fwd_gpio_count_in = 2'h0,
    output logic       fwd_id_load = 1'b0,
    output logic [1:0] fwd_id_port = 2'h0,
    output logic [6:0] fwd_ser_addr_in = 7'h00
);
    // ----
    // load pulses, data inverted once released
    // ----
    task automatic send_ctl(input logic [1:0] p, input logic [1:0] c);
        @(negedge clk_sys);
        fwd_ctl_load = 1'b1;
        fwd_ctl_port = p;
        fwd_gpio_count_in = c;
        @(negedge clk_sys);
        fwd_ctl_load = 1'b0;
        fwd_ctl_port = ~p;
        fwd_gpio_count_in = ~c;
    endtask
    task automatic send_id(input logic [1:0] p, input logic [6:0] a);
        @(negedge clk_sys);
        fwd_id_load = 1'b1;
        fwd_id_port = p;
        fwd_ser_addr_in = a;
        @(negedge clk_sys);
        fwd_id_load = 1'b0;
        fwd_id_port = ~p;
        fwd_ser_addr_in = ~a;
    endtask
endmodule // rprc_ser_model

// ---- sim/tb.sv ----
// testbench for the remap bank
// assumes rprc_bank, its checker and the serializer model
`timescale 1ns/1ps
module tb;
    logic clk_sys = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, txn_req = 1'b0, txn_write = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic [6:0] txn_addr = 7'h00, fwd_ser_addr_in, fwd_addr;
    logic [20:0] tgt_alias_flat = 21'h000000;
    logic fwd_ctl_load, fwd_id_load, fwd_req, local_ack;
    logic [1:0] fwd_ctl_port, fwd_gpio_count_in, fwd_id_port, fwd_port, port_sel;
    logic [2:0] port0_gpio_enabled;
    int errors = 0, compares = 0, cyc = 0;
    rprc_bank DUT (
        .clk_sys            (clk_sys),
        .nrst               (nrst),
        .reg_wr             (reg_wr),
        .reg_rd             (reg_rd),
        .reg_addr           (reg_addr),
        .reg_wdata          (reg_wdata),
        .reg_rdata          (reg_rdata),
        .fwd_ctl_load       (fwd_ctl_load),
        .fwd_ctl_port       (fwd_ctl_port),
        .fwd_gpio_count_in  (fwd_gpio_count_in),
        .fwd_id_load        (fwd_id_load),
        .fwd_id_port        (fwd_id_port),
        .fwd_ser_addr_in    (fwd_ser_addr_in),
        .txn_req            (txn_req),
        .txn_addr           (txn_addr),
        .txn_write          (txn_write),
        .tgt_alias_flat     (tgt_alias_flat),
        .fwd_req            (fwd_req),
        .fwd_port           (fwd_port),
        .fwd_addr           (fwd_addr),
        .local_ack          (local_ack),
        .port0_gpio_enabled (port0_gpio_enabled),
        .port_sel           (port_sel)
    );
    rprc_ser_model ser_m (
        .clk_sys           (clk_sys),
        .fwd_ctl_load      (fwd_ctl_load),
        .fwd_ctl_port      (fwd_ctl_port),
        .fwd_gpio_count_in (fwd_gpio_count_in),
        .fwd_id_load       (fwd_id_load),
        .fwd_id_port       (fwd_id_port),
        .fwd_ser_addr_in   (fwd_ser_addr_in)
    );
    // ----
    // clock, timeout, helpers
    // ----
    initial forever #2.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            errors++;
            results();
        end
    end
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
        @(negedge clk_sys);
        reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk_sys);
        {reg_rd, reg_addr} = {1'b1, a};
        @(negedge clk_sys);
        reg_rd = 1'b0;
        chk("reg_rdata", e, reg_rdata);
    endtask
    task automatic txn(input logic [6:0] a, input logic w, input logic [7:0] e, input logic k);
        @(negedge clk_sys);
        {txn_req, txn_addr, txn_write} = {1'b1, a, w};
        @(negedge clk_sys);
        txn_req = 1'b0;
        chk("fwd_req_addr", e, e[7] ? {fwd_req, fwd_addr} : {fwd_req, 7'h00});
        chk("local_ack", {7'h00, k}, {7'h00, local_ack});
    endtask
    task automatic t_gpio;
        logic [2:0] dec [4] = '{3'h0, 3'h1, 3'h2, 3'h4};
        for (int i = 0; i < 4; i++) begin
            ser_m.send_ctl(2'h0, i[1:0]);
            rd(8'h59, {6'h00, i[1:0]});
            chk("gpio_enabled", {5'h00, dec[i]}, {5'h00, port0_gpio_enabled});
        end
        wr(8'h59, 8'h01);
        rd(8'h59, 8'h03);
        wr(8'h59, 8'hFE);
        rd(8'h59, 8'h82);
        ser_m.send_ctl(2'h0, 2'h1);
        rd(8'h59, 8'h82);
    endtask
    task automatic t_id;
        ser_m.send_id(2'h0, 7'h2A);
        rd(8'h5B, 8'h54);
        wr(8'h5B, 8'h33);
        ser_m.send_id(2'h0, 7'h11);
        rd(8'h5B, 8'h33);
    endtask
    task automatic t_port;
        wr(8'h4C, 8'h01);
        wr(8'h5C, 8'h62);
        txn(7'h31, 1'b1, 8'h80, 1'b0);
        chk("fwd_port", 8'h01, {6'h00, fwd_port});
        chk("port_sel", 8'h01, {6'h00, port_sel});
        wr(8'h5E, 8'hAB);
        rd(8'h5E, 8'hAA);
        wr(8'h4C, 8'h00);
        rd(8'h5E, 8'h00);
    endtask
    task automatic t_txn;
        wr(8'h5C, 8'h81);
        wr(8'h5D, 8'hA0);
        tgt_alias_flat = 21'h000021;
        txn(7'h40, 1'b1, 8'h99, 1'b1);
        txn(7'h40, 1'b0, 8'h99, 1'b0);
        txn(7'h21, 1'b1, 8'hD0, 1'b0);
        txn(7'h22, 1'b1, 8'h00, 1'b0);
        wr(8'h5C, 8'h00);
        txn(7'h00, 1'b1, 8'h00, 1'b0);
    endtask
    task automatic results;
        if (errors == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (2) @(negedge clk_sys);
        nrst = 1'b1;
        for (int a = 8'h58; a < 8'h61; a++) rd(a[7:0], 8'h00);
        t_gpio();
        t_id();
        t_port();
        t_txn();
        results();
    end
endmodule // tb
